// ===== verilog/mcs_regs.vh
// Constants for the multipoint calibration sequencer: states, command and
// answer codes, point counts and indices and read timing. Included by the sequencer, the property checks and the directed test.
// Notes on behaviour
// [RQ1] Six-point ratio mode is entered only after a calibration has been opened.
// [RQ2] Ratio mass, torque and value entries act only after begin and six-point.
// [RQ3] Ratio entry and value commands carry point index 1 to 6, or 0.
// [RQ4] Host sends ratio mass entry as command, index, value, then hash.
// [RQ5] After a ratio mass or torque entry, prompt for that point's mV/V value.
// [RQ6] Host sends each mV/V value with the value entry command and index.
// [RQ7] Prompts alternate per point; after six points, request the completion command.
// [RQ8] Ratio mass index 0 starts shunt read, waits 10 s, then reports completion.
// [RQ9] Escape drops the calibration in progress; stored calibration stays unchanged.
// [RQ10] Ratio torque entries follow the same sequencing and prompting as mass entries.
// [RQ11] Ratio torque index 0 runs a 10 s shunt read, then reports completion.
// [RQ12] Mass method carries a point count of two or five, fixing points expected.
// [RQ13] Mass points take index 1 to 5 or 0, only after begin and method.
// [RQ14] Each mass point samples the cell for 10 s and averages the samples.
// [RQ15] When a point read ends, report readiness for next point or escape.
// [RQ16] Point n is accepted only after point n-1 has finished its read.
// [RQ17] Mass point index 0 ends the calibration with a kept shunt measurement.
// [RQ18] Torque method carries two or five, acknowledged with readiness for point 1.
// [RQ19] Torque points need begin and torque method; each runs a 10 s averaged read.
// [RQ20] Operator loads the cell before a point command; sampling starts at once.
// [RQ21] Operator unloads the cell before the six-point completion command.
// [RQ22] Any non-calibration remote command cancels a calibration in progress.
// [RQ23] Calibration commands out of sequence are ignored with no state change.
`ifndef MCS_REGS_VH
`define MCS_REGS_VH

// ==================================================================
// Sequencer states
`define MCS_ST_IDLE 3'h0
`define MCS_ST_OPEN 3'h1
`define MCS_ST_R_ENTRY 3'h2
`define MCS_ST_R_VAL 3'h3
`define MCS_ST_R_FINAL 3'h4
`define MCS_ST_P_READY 3'h5
`define MCS_ST_P_READ 3'h6
`define MCS_ST_SHUNT 3'h7

// ==================================================================
// Decoded command codes from the serial command parser
`define MCS_CMD_BEGIN 4'h1
`define MCS_CMD_SIX 4'h2
`define MCS_CMD_RMASS 4'h3
`define MCS_CMD_RTORQ 4'h4
`define MCS_CMD_RVAL 4'h5
`define MCS_CMD_MMETH 4'h6
`define MCS_CMD_MPOINT 4'h7
`define MCS_CMD_TMETH 4'h8
`define MCS_CMD_TPOINT 4'h9
`define MCS_CMD_ESC 4'ha
`define MCS_CMD_OTHER 4'hb

// ==================================================================
// Answer codes for the message formatter
`define MCS_ACK_SIX_READY 4'h1
`define MCS_ACK_PROMPT_VAL 4'h2
`define MCS_ACK_PROMPT_ENTRY 4'h3
`define MCS_ACK_REQ_FINAL 4'h4
`define MCS_ACK_METHOD 4'h5
`define MCS_ACK_READING 4'h6
`define MCS_ACK_READY_NEXT 4'h7
`define MCS_ACK_SHUNT 4'h8
`define MCS_ACK_COMPLETE 4'h9
`define MCS_ACK_CANCELED 4'ha

// ==================================================================
// Point counts and indices
`define MCS_RATIO_POINTS 3'h6
`define MCS_PTS_TWO 3'h2
`define MCS_PTS_FIVE 3'h5
`define MCS_IDX_FINAL 3'h0
`define MCS_IDX_FIRST 3'h1
`define MCS_KIND_ENTRY 1'b0
`define MCS_KIND_VALUE 1'b1

// ==================================================================
// Read timing
`define MCS_READ_TIME_S 10
`define MCS_CLK_HZ 200000000

`endif

// ===== verilog/mcs_read_timer.v
// Timed read window: counts a fixed number of clock cycles after start.
// Assumes start and abort are single-cycle pulses from the sequencer.
`timescale 1ns/1ps
module mcs_read_timer #(
  parameter CNT_W = 32,
  parameter [CNT_W-1:0] CYCLES = 32'd100
) (
  input wire core_clk,
  input wire rst_n,
  input wire start,
  input wire abort,
  output reg busy_q,
  output reg done_q
);

  reg [CNT_W-1:0] cnt_q;

  // ==================================================================
  // Down counter; abort wins so an escape never yields a late done
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= {CNT_W{1'b0}};
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (abort)
      begin
        busy_q <= 1'b0;
      end
      else if (start)
      begin
        cnt_q <= CYCLES - {{(CNT_W-1){1'b0}}, 1'b1};
        busy_q <= 1'b1;
      end
      else if (busy_q)
      begin
        if (cnt_q == {CNT_W{1'b0}})
        begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
        else
        begin
          cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

// ===== verilog/mcs_point_store.v
// Scratch store for entered point values (entries and mV/V values).
// Assumes one write and one read per cycle; read data is registered.
`timescale 1ns/1ps
module mcs_point_store #(
  parameter DW = 32,
  parameter AW = 4
) (
  input wire core_clk,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [DW-1:0] rd_data_q
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // ==================================================================
  // No reset on the array; words are only meaningful once written
  always @(posedge core_clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_q <= mem[rd_addr];
  end

endmodule

// ===== verilog/mcs_sequencer.v
// Multipoint calibration sequencer: gates the order of decoded calibration
// commands, times averaged cell reads and the closing shunt read.
// Assumes an upstream parser delivers one decoded command per cmd_valid
// pulse, with the numeric argument already converted, and that cell samples
// arrive on sample_valid. The fitting arithmetic reads the store downstream.
`timescale 1ns/1ps
`include "mcs_regs.vh"
module mcs_sequencer #(
  parameter VAL_W = 32,
  parameter SMP_W = 24,
  parameter SUM_W = 56,
  parameter CNT_W = 32,
  parameter [CNT_W-1:0] READ_CYCLES = `MCS_READ_TIME_S * `MCS_CLK_HZ
) (
  input wire core_clk,
  input wire rst_n,
  input wire cmd_valid,
  input wire [3:0] cmd_code,
  input wire [2:0] cmd_index,
  input wire [VAL_W-1:0] cmd_value,
  input wire sample_valid,
  input wire [SMP_W-1:0] sample_data,
  input wire [3:0] rd_addr,
  output reg ack_valid_q,
  output reg [3:0] ack_code_q,
  output reg [2:0] ack_index_q,
  output reg cal_active_q,
  output reg torque_q,
  output wire reading_q,
  output reg commit_q,
  output reg cancel_q,
  output reg result_valid_q,
  output reg [2:0] result_index_q,
  output reg [SUM_W-1:0] result_sum_q,
  output reg [CNT_W-1:0] result_count_q,
  output wire [VAL_W-1:0] rd_data_q
);

  // ==================================================================
  // State
  reg [2:0] st_q;
  reg [2:0] st_d;
  reg [2:0] idx_q;
  reg [2:0] idx_d;
  reg [2:0] npts_q;
  reg [2:0] npts_d;
  reg torque_d;
  reg [SUM_W-1:0] sum_q;
  reg [CNT_W-1:0] cnt_q;

  reg ack_d;
  reg [3:0] ack_code_d;
  reg [2:0] ack_index_d;
  reg start;
  reg abort;
  reg wr_en;
  reg wr_kind;
  reg commit_d;
  reg cancel_d;
  reg result_d;

  wire rd_done;
  wire is_entry;
  wire is_point;
  wire fam_entry_ok;
  wire fam_point_ok;
  wire is_cancel;
  wire [SUM_W-1:0] sample_ext;

  assign is_entry = (cmd_code == `MCS_CMD_RMASS) || (cmd_code == `MCS_CMD_RTORQ);
  assign is_point = (cmd_code == `MCS_CMD_MPOINT) || (cmd_code == `MCS_CMD_TPOINT);
  // First ratio entry picks the family; later ones must match it
  assign fam_entry_ok = (idx_q == `MCS_IDX_FIRST) ||
                        ((cmd_code == `MCS_CMD_RTORQ) == torque_q); // [RQ10]
  assign fam_point_ok = (cmd_code == `MCS_CMD_TPOINT) == torque_q;
  assign is_cancel = cmd_valid && (st_q != `MCS_ST_IDLE) &&
                     ((cmd_code == `MCS_CMD_ESC) || (cmd_code == `MCS_CMD_OTHER));
  assign sample_ext = {{(SUM_W-SMP_W){sample_data[SMP_W-1]}}, sample_data};

  // ==================================================================
  // Next-state and command acceptance
  always @*
  begin
    st_d = st_q;
    idx_d = idx_q;
    npts_d = npts_q;
    torque_d = torque_q;
    ack_d = 1'b0;
    ack_code_d = ack_code_q;
    ack_index_d = ack_index_q;
    start = 1'b0;
    abort = 1'b0;
    wr_en = 1'b0;
    wr_kind = `MCS_KIND_ENTRY;
    commit_d = 1'b0;
    cancel_d = 1'b0;
    result_d = 1'b0;
    if (is_cancel)
    begin
      // Store is scratch only, so dropping here leaves the old calibration
      abort = 1'b1; // [RQ9]
      cancel_d = 1'b1; // [RQ22]
      ack_d = 1'b1;
      ack_code_d = `MCS_ACK_CANCELED;
      ack_index_d = `MCS_IDX_FINAL;
      st_d = `MCS_ST_IDLE;
    end
    else if (rd_done)
    begin
      result_d = 1'b1; // [RQ14]
      ack_d = 1'b1;
      if (st_q == `MCS_ST_SHUNT)
      begin
        ack_code_d = `MCS_ACK_COMPLETE; // [RQ8] [RQ11] [RQ17]
        ack_index_d = `MCS_IDX_FINAL;
        commit_d = 1'b1;
        st_d = `MCS_ST_IDLE;
      end
      else
      begin
        ack_code_d = `MCS_ACK_READY_NEXT; // [RQ15]
        ack_index_d = idx_q;
        idx_d = idx_q + 3'h1; // [RQ16]
        st_d = `MCS_ST_P_READY;
      end
    end
    else if (cmd_valid && (cmd_code == `MCS_CMD_BEGIN))
    begin
      // Reopening drops a running read so its done cannot land in the new run
      abort = 1'b1; // [RQ23]
      st_d = `MCS_ST_OPEN;
      idx_d = `MCS_IDX_FIRST;
    end
    else if (cmd_valid)
    begin
      // Anything not matched below is dropped with no effect [RQ23]
      case (st_q)
        `MCS_ST_OPEN:
        begin
          if (cmd_code == `MCS_CMD_SIX)
          begin
            st_d = `MCS_ST_R_ENTRY; // [RQ1]
            idx_d = `MCS_IDX_FIRST;
            ack_d = 1'b1;
            ack_code_d = `MCS_ACK_SIX_READY;
            ack_index_d = `MCS_IDX_FIRST;
          end
          else if (((cmd_code == `MCS_CMD_MMETH) || (cmd_code == `MCS_CMD_TMETH)) &&
                   ((cmd_index == `MCS_PTS_TWO) || (cmd_index == `MCS_PTS_FIVE)))
          begin
            st_d = `MCS_ST_P_READY; // [RQ12] [RQ18]
            npts_d = cmd_index;
            torque_d = (cmd_code == `MCS_CMD_TMETH);
            idx_d = `MCS_IDX_FIRST;
            ack_d = 1'b1;
            ack_code_d = `MCS_ACK_METHOD;
            ack_index_d = cmd_index;
          end
        end
        `MCS_ST_R_ENTRY:
        begin
          if (is_entry && fam_entry_ok && (cmd_index == idx_q)) // [RQ2] [RQ3] [RQ4]
          begin
            torque_d = (cmd_code == `MCS_CMD_RTORQ);
            wr_en = 1'b1;
            st_d = `MCS_ST_R_VAL;
            ack_d = 1'b1;
            ack_code_d = `MCS_ACK_PROMPT_VAL; // [RQ5]
            ack_index_d = idx_q;
          end
        end
        `MCS_ST_R_VAL:
        begin
          if ((cmd_code == `MCS_CMD_RVAL) && (cmd_index == idx_q)) // [RQ6]
          begin
            wr_en = 1'b1;
            wr_kind = `MCS_KIND_VALUE;
            ack_d = 1'b1;
            if (idx_q == `MCS_RATIO_POINTS)
            begin
              st_d = `MCS_ST_R_FINAL;
              ack_code_d = `MCS_ACK_REQ_FINAL; // [RQ7]
              ack_index_d = `MCS_IDX_FINAL;
            end
            else
            begin
              st_d = `MCS_ST_R_ENTRY;
              idx_d = idx_q + 3'h1;
              ack_code_d = `MCS_ACK_PROMPT_ENTRY; // [RQ7]
              ack_index_d = idx_q + 3'h1;
            end
          end
        end
        `MCS_ST_R_FINAL:
        begin
          if (is_entry && ((cmd_code == `MCS_CMD_RTORQ) == torque_q) &&
              (cmd_index == `MCS_IDX_FINAL))
          begin
            // Operator must have unloaded the cell by now [RQ21]
            start = 1'b1; // [RQ8] [RQ11]
            st_d = `MCS_ST_SHUNT;
            ack_d = 1'b1;
            ack_code_d = `MCS_ACK_SHUNT;
            ack_index_d = `MCS_IDX_FINAL;
          end
        end
        `MCS_ST_P_READY:
        begin
          if (is_point && fam_point_ok) // [RQ13] [RQ19]
          begin
            if ((cmd_index == `MCS_IDX_FINAL) && (idx_q == npts_q + 3'h1))
            begin
              start = 1'b1; // [RQ17]
              st_d = `MCS_ST_SHUNT;
              ack_d = 1'b1;
              ack_code_d = `MCS_ACK_SHUNT;
              ack_index_d = `MCS_IDX_FINAL;
            end
            else if ((cmd_index == idx_q) && (idx_q <= npts_q)) // [RQ16]
            begin
              // Sampling starts the next cycle; load must already be applied [RQ20]
              start = 1'b1; // [RQ14] [RQ19]
              wr_en = 1'b1;
              st_d = `MCS_ST_P_READ;
              ack_d = 1'b1;
              ack_code_d = `MCS_ACK_READING;
              ack_index_d = idx_q;
            end
          end
        end
        default:
        begin
          st_d = st_q;
        end
      endcase
    end
  end

  // ==================================================================
  // Sequencer registers
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= `MCS_ST_IDLE;
      idx_q <= `MCS_IDX_FIRST;
      npts_q <= `MCS_PTS_TWO;
      torque_q <= 1'b0;
      cal_active_q <= 1'b0;
      ack_valid_q <= 1'b0;
      ack_code_q <= 4'h0;
      ack_index_q <= 3'h0;
      commit_q <= 1'b0;
      cancel_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      idx_q <= idx_d;
      npts_q <= npts_d;
      torque_q <= torque_d;
      cal_active_q <= (st_d != `MCS_ST_IDLE);
      ack_valid_q <= ack_d;
      ack_code_q <= ack_code_d;
      ack_index_q <= ack_index_d;
      commit_q <= commit_d;
      cancel_q <= cancel_d;
    end
  end

  // ==================================================================
  // Averaging accumulator; sum and count go out, division is downstream
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sum_q <= {SUM_W{1'b0}};
      cnt_q <= {CNT_W{1'b0}};
      result_valid_q <= 1'b0;
      result_index_q <= 3'h0;
      result_sum_q <= {SUM_W{1'b0}};
      result_count_q <= {CNT_W{1'b0}};
    end
    else
    begin
      result_valid_q <= result_d;
      if (start)
      begin
        sum_q <= {SUM_W{1'b0}};
        cnt_q <= {CNT_W{1'b0}};
      end
      else if (reading_q && sample_valid)
      begin
        sum_q <= sum_q + sample_ext; // [RQ14]
        cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      if (result_d)
      begin
        result_sum_q <= sum_q;
        result_count_q <= cnt_q;
        result_index_q <= (st_q == `MCS_ST_SHUNT) ? `MCS_IDX_FINAL : idx_q;
      end
    end
  end

  // ==================================================================
  // Read window timer and point store
  mcs_read_timer #(
    .CNT_W(CNT_W),
    .CYCLES(READ_CYCLES)
  ) u_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .start(start),
    .abort(abort),
    .busy_q(reading_q),
    .done_q(rd_done)
  );

  mcs_point_store #(
    .DW(VAL_W),
    .AW(4)
  ) u_store (
    .core_clk(core_clk),
    .wr_en(wr_en),
    .wr_addr({wr_kind, idx_q}),
    .wr_data(cmd_value),
    .rd_addr(rd_addr),
    .rd_data_q(rd_data_q)
  );

endmodule

// ===== bench/mcs_seq_props.sv
// Port-level checks for the calibration sequencer.
// Bound to mcs_sequencer from the bench top; one clock domain.
`timescale 1ns/1ps
`include "mcs_regs.vh"
module mcs_seq_props #(
  parameter CNT_W = 32,
  parameter [CNT_W-1:0] READ_CYCLES = 32'd100
) (
  input wire core_clk,
  input wire rst_n,
  input wire cmd_valid,
  input wire [3:0] cmd_code,
  input wire ack_valid_q,
  input wire [3:0] ack_code_q,
  input wire [2:0] ack_index_q,
  input wire cal_active_q,
  input wire reading_q,
  input wire commit_q,
  input wire cancel_q,
  input wire result_valid_q,
  input wire [2:0] result_index_q
);
  // ==================================================================
  // Length of the last read window, held until the next one starts
  reg [CNT_W-1:0] len_q;
  reg was_q;
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      len_q <= {CNT_W{1'b0}};
      was_q <= 1'b0;
    end
    else
    begin
      was_q <= reading_q;
      if (reading_q)
        len_q <= was_q ? len_q + 1'b1 : {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end
  wire cmd_act = cmd_valid && cal_active_q;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // ==================================================================
  // Assertions
  sequence s_cancel;
    ack_valid_q && ack_code_q == `MCS_ACK_CANCELED && cancel_q && !commit_q && !cal_active_q
    ##1 !ack_valid_q;
  endsequence
  sequence s_done;
    commit_q && result_valid_q && result_index_q == `MCS_IDX_FINAL && !cal_active_q
    ##1 !ack_valid_q;
  endsequence
  AST_ESC: assert property (cmd_act && cmd_code == `MCS_CMD_ESC |=> s_cancel)
    else $error("escape did not cancel");
  AST_OTHER: assert property (cmd_act && cmd_code == `MCS_CMD_OTHER |=> s_cancel)
    else $error("foreign command did not cancel");
  AST_IDLE: assert property (cmd_valid && !cal_active_q && cmd_code != `MCS_CMD_BEGIN
    |=> !ack_valid_q) else $error("command answered while idle");
  AST_RDLEN: assert property (ack_valid_q && (ack_code_q == `MCS_ACK_READY_NEXT
    || ack_code_q == `MCS_ACK_COMPLETE) |-> len_q == READ_CYCLES)
    else $error("read window length wrong");
  AST_READING: assert property (ack_valid_q && ack_code_q == `MCS_ACK_READING
    |-> $rose(reading_q)) else $error("point read did not start");
  AST_SHUNT: assert property (ack_valid_q && ack_code_q == `MCS_ACK_SHUNT
    |-> $rose(reading_q)) else $error("shunt read did not start");
  AST_NEXT: assert property (ack_valid_q && ack_code_q == `MCS_ACK_READY_NEXT
    |-> result_valid_q && result_index_q == ack_index_q && !reading_q)
    else $error("ready ack without result");
  AST_DONE: assert property (ack_valid_q && ack_code_q == `MCS_ACK_COMPLETE |-> s_done)
    else $error("completion without commit");
  AST_BUSYPT: assert property (reading_q && cmd_valid && cmd_code == `MCS_CMD_MPOINT
    |=> !(ack_valid_q && ack_code_q == `MCS_ACK_READING))
    else $error("point taken during read");
  AST_METH: assert property (ack_valid_q && ack_code_q == `MCS_ACK_METHOD
    |-> ack_index_q == `MCS_PTS_TWO || ack_index_q == `MCS_PTS_FIVE)
    else $error("bad point count accepted");
endmodule

// ===== bench/mcs_host_model.sv
// Host terminal and the cell under load, on the sequencer's far side.
// Drives decoded commands and cell samples after the falling edge.
`timescale 1ns/1ps
module mcs_host_model (
  input wire core_clk,
  output reg cmd_valid,
  output reg [3:0] cmd_code,
  output reg [2:0] cmd_index,
  output reg [31:0] cmd_value,
  output reg sample_valid,
  output reg [23:0] sample_data
);
  reg [23:0] load;
  reg [1:0] tick;
  initial
  begin
    cmd_valid = 1'b0;
    cmd_code = 4'h0;
    cmd_index = 3'h0;
    cmd_value = 32'h0;
    sample_valid = 1'b0;
    sample_data = 24'h0;
    load = 24'h0;
    tick = 2'h0;
  end
  // Between samples the data lines carry junk so stale values never count
  always @(negedge core_clk)
  begin
    tick <= tick + 2'h1;
    sample_valid <= tick == 2'h0;
    sample_data <= tick == 2'h0 ? load : ~load;
  end
  task set_load(input [23:0] l);
    load = l;
  endtask
  // Command, index and value are whole in one pulse
  task send(input [3:0] c, input [2:0] i, input [31:0] v);
    begin
      @(negedge core_clk);
      cmd_valid = 1'b1;
      cmd_code = c;
      cmd_index = i;
      cmd_value = v;
      @(negedge core_clk);
      cmd_valid = 1'b0;
      cmd_code = ~c;
      cmd_index = ~i;
      cmd_value = ~v;
    end
  endtask
endmodule

// ===== bench/multipoint_calibration_sequencer_test.sv
// Directed bench for the calibration sequencer.
// Uses a short read window so each timed read lasts RC cycles.
`timescale 1ns/1ps
`include "mcs_regs.vh"
module multipoint_calibration_sequencer_test;
  localparam RC = 20;
  reg core_clk = 1'b0;
  reg rst_n = 1'b0;
  reg [3:0] rd_addr = 4'h0;
  wire cmd_valid;
  wire [3:0] cmd_code;
  wire [2:0] cmd_index;
  wire [31:0] cmd_value;
  wire sample_valid;
  wire [23:0] sample_data;
  wire ack_valid_q;
  wire [3:0] ack_code_q;
  wire [2:0] ack_index_q;
  wire cal_active_q;
  wire torque_q;
  wire reading_q;
  wire commit_q;
  wire cancel_q;
  wire result_valid_q;
  wire [2:0] result_index_q;
  wire [55:0] result_sum_q;
  wire [31:0] result_count_q;
  wire [31:0] rd_data_q;
  reg s_commit;
  reg s_cancel;
  reg [2:0] s_ridx;
  reg [55:0] s_sum;
  reg [31:0] s_cnt;
  integer n_mismatch = 0;
  integer n_compared = 0;
  integer cyc = 0;
  always #2.5 core_clk = ~core_clk;
  mcs_sequencer #(.READ_CYCLES(RC)) mcs_sequencer_inst (.core_clk, .rst_n, .cmd_valid,
    .cmd_code, .cmd_index, .cmd_value, .sample_valid, .sample_data, .rd_addr,
    .ack_valid_q, .ack_code_q, .ack_index_q, .cal_active_q, .torque_q, .reading_q,
    .commit_q, .cancel_q, .result_valid_q, .result_index_q, .result_sum_q,
    .result_count_q, .rd_data_q);
  mcs_host_model mcs_host_model_inst (.core_clk, .cmd_valid, .cmd_code, .cmd_index,
    .cmd_value, .sample_valid, .sample_data);
  // ==================================================================
  // Shared tasks
  task test_done;
    begin
      $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task chk(input [255:0] what, input [63:0] exp, input [63:0] got);
    begin
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value %0s: expected %0h, seen %0h", what, exp, got);
      end
    end
  endtask
  task send(input [3:0] c, input [2:0] i);
    mcs_host_model_inst.send(c, i, {24'h0, c, 1'b0, i});
  endtask
  // Index argument with bit 3 set means the index is not checked
  task wait_ack(input [3:0] c, input [3:0] i);
    integer k;
    begin
      k = 0;
      while (ack_valid_q !== 1'b1 && k < 3 * RC)
      begin
        @(negedge core_clk);
        k = k + 1;
      end
      chk("ack valid", 1, ack_valid_q);
      chk("ack code", c, ack_code_q);
      if (!i[3])
        chk("ack index", i, ack_index_q);
      s_commit = commit_q;
      s_cancel = cancel_q;
      s_ridx = result_index_q;
      s_sum = result_sum_q;
      s_cnt = result_count_q;
      @(negedge core_clk);
    end
  endtask
  task no_ack;
    repeat (3)
    begin
      chk("no ack", 0, ack_valid_q);
      @(negedge core_clk);
    end
  endtask
  task finish_cal(input [3:0] c);
    begin
      mcs_host_model_inst.set_load(24'h0);
      send(c, 3'h0);
      wait_ack(`MCS_ACK_SHUNT, 4'h8);
      wait_ack(`MCS_ACK_COMPLETE, 4'h8);
      chk("commit", 1, s_commit);
      chk("final index", 0, s_ridx);
    end
  endtask
  // ==================================================================
  // Scenarios
  task t_gate;
    begin
      send(`MCS_CMD_SIX, 3'h0);
      no_ack;
      send(`MCS_CMD_ESC, 3'h0);
      no_ack;
      send(`MCS_CMD_BEGIN, 3'h0);
      no_ack;
      send(`MCS_CMD_RMASS, 3'h1);
      no_ack;
      send(`MCS_CMD_MPOINT, 3'h1);
      no_ack;
      send(`MCS_CMD_TPOINT, 3'h1);
      no_ack;
      send(`MCS_CMD_MMETH, 3'h3);
      no_ack;
    end
  endtask
  task t_ratio(input [3:0] fam);
    integer n;
    begin
      send(`MCS_CMD_BEGIN, 3'h0);
      send(`MCS_CMD_SIX, 3'h0);
      wait_ack(`MCS_ACK_SIX_READY, 4'h1);
      send(`MCS_CMD_RVAL, 3'h1);
      no_ack;
      send(fam, 3'h7);
      no_ack;
      for (n = 1; n <= 6; n = n + 1)
      begin
        send(fam, n[2:0]);
        wait_ack(`MCS_ACK_PROMPT_VAL, n[3:0]);
        if (n == 3)
        begin
          send(fam, 3'h0);
          no_ack;
        end
        send(`MCS_CMD_RVAL, n[2:0]);
        wait_ack(n == 6 ? `MCS_ACK_REQ_FINAL : `MCS_ACK_PROMPT_ENTRY,
          n == 6 ? 4'h8 : n[3:0] + 4'h1);
      end
      chk("family", fam == `MCS_CMD_RTORQ, torque_q);
      finish_cal(fam);
      rd_addr = {`MCS_KIND_ENTRY, 3'h3};
      repeat (2) @(negedge core_clk);
      chk("stored entry", {24'h0, fam, 4'h3}, rd_data_q);
      rd_addr = {`MCS_KIND_VALUE, 3'h3};
      repeat (2) @(negedge core_clk);
      chk("stored value", {24'h0, `MCS_CMD_RVAL, 4'h3}, rd_data_q);
    end
  endtask
  task t_point(input [3:0] meth, input [3:0] pc, input [2:0] cnt);
    integer n;
    reg [23:0] ld;
    begin
      send(`MCS_CMD_BEGIN, 3'h0);
      send(meth, cnt);
      wait_ack(`MCS_ACK_METHOD, {1'b0, cnt});
      send(pc, 3'h2);
      no_ack;
      send(pc, 3'h0);
      no_ack;
      for (n = 1; n <= cnt; n = n + 1)
      begin
        ld = 24'h40 * n;
        mcs_host_model_inst.set_load(ld);
        send(pc, n[2:0]);
        wait_ack(`MCS_ACK_READING, n[3:0]);
        send(pc, n[2:0] + 3'h1);
        no_ack;
        wait_ack(`MCS_ACK_READY_NEXT, n[3:0]);
        chk("result index", n[2:0], s_ridx);
        chk("samples taken", RC / 4, s_cnt);
        chk("sample sum", s_cnt * ld, s_sum);
      end
      chk("family", pc == `MCS_CMD_TPOINT, torque_q);
      finish_cal(pc);
    end
  endtask
  task t_cancel;
    begin
      send(`MCS_CMD_BEGIN, 3'h0);
      send(`MCS_CMD_MMETH, `MCS_PTS_TWO);
      wait_ack(`MCS_ACK_METHOD, 4'h2);
      send(`MCS_CMD_MPOINT, 3'h1);
      wait_ack(`MCS_ACK_READING, 4'h1);
      repeat (RC / 2) @(negedge core_clk);
      send(`MCS_CMD_ESC, 3'h0);
      wait_ack(`MCS_ACK_CANCELED, 4'h8);
      chk("cancel", 1, s_cancel);
      chk("commit", 0, s_commit);
      chk("reading", 0, reading_q);
      chk("active", 0, cal_active_q);
      send(`MCS_CMD_MPOINT, 3'h2);
      no_ack;
      send(`MCS_CMD_BEGIN, 3'h0);
      send(`MCS_CMD_SIX, 3'h0);
      wait_ack(`MCS_ACK_SIX_READY, 4'h1);
      send(`MCS_CMD_OTHER, 3'h0);
      wait_ack(`MCS_ACK_CANCELED, 4'h8);
      chk("cancel", 1, s_cancel);
      send(`MCS_CMD_BEGIN, 3'h0);
      send(`MCS_CMD_MMETH, `MCS_PTS_TWO);
      wait_ack(`MCS_ACK_METHOD, 4'h2);
      send(`MCS_CMD_MPOINT, 3'h1);
      wait_ack(`MCS_ACK_READING, 4'h1);
      send(`MCS_CMD_BEGIN, 3'h0);
      chk("reading", 0, reading_q);
      repeat (RC) no_ack;
    end
  endtask
  // ==================================================================
  // Main sequence and hang guard
  always @(posedge core_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 8000)
    begin
      n_mismatch = n_mismatch + 1;
      test_done;
    end
  end
  initial
  begin
    repeat (20) @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    t_gate;
    t_ratio(`MCS_CMD_RMASS);
    t_ratio(`MCS_CMD_RTORQ);
    t_point(`MCS_CMD_MMETH, `MCS_CMD_MPOINT, `MCS_PTS_TWO);
    t_point(`MCS_CMD_MMETH, `MCS_CMD_MPOINT, `MCS_PTS_FIVE);
    t_point(`MCS_CMD_TMETH, `MCS_CMD_TPOINT, `MCS_PTS_TWO);
    t_point(`MCS_CMD_TMETH, `MCS_CMD_TPOINT, `MCS_PTS_FIVE);
    t_cancel;
    test_done;
  end
endmodule
bind mcs_sequencer mcs_seq_props #(.CNT_W(CNT_W), .READ_CYCLES(READ_CYCLES))
  mcs_seq_props_inst (.core_clk, .rst_n, .cmd_valid, .cmd_code, .ack_valid_q,
  .ack_code_q, .ack_index_q, .cal_active_q, .reading_q, .commit_q, .cancel_q,
  .result_valid_q, .result_index_q);
